/* File: rtl/pssw_pkg.sv */
// Purpose: shared constants and types for the protection switch status block
// Assumes: one 10 MHz clock, synchronous active-high reset
// Notes:   register offsets are word indices on a plain strobe port
package pssw_pkg;

    // ************************************************************
    // sizing
    // ************************************************************
    localparam int PSSW_NUM_PRIME   = 8;
    localparam int PSSW_NUM_BACKUP  = 2;
    localparam int PSSW_POLES_RS449 = 10;
    localparam int PSSW_POLES_V35   = 8;
    localparam int PSSW_AW          = 4;
    localparam int PSSW_DW          = 32;

    // ************************************************************
    // timing
    // ************************************************************
    localparam int PSSW_CLK_HZ        = 10_000_000;
    localparam int PSSW_MONO_US       = 1000;
    localparam int PSSW_MONO_CYC      = PSSW_MONO_US * (PSSW_CLK_HZ / 1_000_000);
    localparam int PSSW_KICK_US       = 250;
    localparam int PSSW_KICK_CYC      = PSSW_KICK_US * (PSSW_CLK_HZ / 1_000_000);

    // ************************************************************
    // register indices
    // ************************************************************
    localparam logic [3:0] PSSW_REG_CTRL    = 4'h0;
    localparam logic [3:0] PSSW_REG_MODSEL  = 4'h1;
    localparam logic [3:0] PSSW_REG_DEMSEL  = 4'h2;
    localparam logic [3:0] PSSW_REG_FAULT   = 4'h3;
    localparam logic [3:0] PSSW_REG_STATUS  = 4'h4;
    localparam logic [3:0] PSSW_REG_ONLINE  = 4'h5;
    localparam logic [3:0] PSSW_REG_RXFLT   = 4'h6;
    localparam logic [3:0] PSSW_REG_TXFLT   = 4'h7;

    // ctrl fields
    localparam int PSSW_CTRL_RUN     = 0;
    localparam int PSSW_CTRL_WHOLE   = 1;
    localparam int PSSW_CTRL_REMOTE  = 2;
    localparam int PSSW_CTRL_RS449   = 3;
    localparam logic [3:0] PSSW_CTRL_RST = 4'h0;

    // fault cause fields
    localparam int PSSW_FLT_BACKUP   = 0;
    localparam int PSSW_FLT_COMM     = 1;
    localparam int PSSW_FLT_CONFIG   = 2;
    localparam int PSSW_FLT_SETUP    = 3;

    // per-prime selection code: 0 prime, 1 backup one, 3 backup two
    typedef enum logic [1:0] {
        PSSW_SEL_PRIME = 2'b00,
        PSSW_SEL_BU1   = 2'b01,
        PSSW_SEL_BU2   = 2'b11
    } pssw_sel_t;

    typedef struct packed {
        logic ctrl_ok;
        logic prot_fault;
        logic rx_fault;
    } pssw_alarm_t;

    typedef struct packed {
        logic [PSSW_AW-1:0] addr;
        logic [PSSW_DW-1:0] wdata;
        logic               wr;
        logic               rd;
    } pssw_bus_t;

endpackage : pssw_pkg

/* File: rtl/pssw_status.sv */
// Purpose: fault summary, online status and routing select of a 1:N switch
// Assumes: fault inputs synchronous to clk, high means fault
// Notes:   relay outputs high means coil energized
// Operation
// - three separate non-latching summary outputs: controller, protection, receive.
// - periodic timer retriggers monostable; controller output drops when retrigger stops.
// - controller output stays energized while the monostable is kept triggered.
// - protection fault raised for backup, comm, config or setup failures.
// - protection output off normally, on during failure until failure clears.
// - receive output on only when all active demodulators lost carrier.
// - receive output returns off once the all-lost condition is gone.
// - one online status output per prime modulator and demodulator.
// - modulator online output energized while a backup modulator serves prime.
// - demodulator online output energized while a backup demodulator serves.
// - default or reset state routes every position straight to its prime.
// - independent variant switches transmit and receive groups separately.
// - whole-modem variant moves both groups on either prime fault.
// - clock set steered to standby backup or offline prime on backup.
// - fault inputs taken only from prime and backup modem ports.
// - RS-449 routing unit switches ten poles per group.
// - V.35 routing unit switches eight poles per group.
// - eight prime positions and two backup positions are addressable.
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module pssw_status
    import pssw_pkg::*;
#(
    parameter int NUM_PRIME = PSSW_NUM_PRIME,
    parameter int MONO_CYC  = PSSW_MONO_CYC,
    parameter int KICK_CYC  = PSSW_KICK_CYC
) (
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     reset,
    // register port
    input  wire logic [PSSW_AW-1:0]       addr,
    input  wire logic [PSSW_DW-1:0]       wdata,
    input  wire logic                     wr,
    input  wire logic                     rd,
    output logic      [PSSW_DW-1:0]       rdata,
    // modem fault lines, prime then backup ports
    input  wire logic [NUM_PRIME-1:0]     tx_unit_fault_in,
    input  wire logic [NUM_PRIME-1:0]     rx_unit_fault_in,
    input  wire logic [PSSW_NUM_BACKUP-1:0] bu_tx_fault_in,
    input  wire logic [PSSW_NUM_BACKUP-1:0] bu_rx_fault_in,
    // station alarm relays
    output pssw_pkg::pssw_alarm_t         alarm,
    // online telemetry relays
    output logic      [NUM_PRIME-1:0]     mod_online,
    output logic      [NUM_PRIME-1:0]     demod_online,
    // routing relay drives per prime, pole group mask and backup clocks
    output logic      [2*NUM_PRIME-1:0]   tx_route,
    output logic      [2*NUM_PRIME-1:0]   rx_route,
    output logic      [PSSW_POLES_RS449-1:0] pole_mask,
    output logic      [NUM_PRIME-1:0]     clk_to_prime,
    output logic      [PSSW_NUM_BACKUP-1:0] clk_to_backup
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    initial begin
        if (NUM_PRIME < 1 || NUM_PRIME > PSSW_NUM_PRIME)
            $error("prime count out of range");
        if (KICK_CYC < 1 || KICK_CYC >= MONO_CYC)
            $error("kick period must be shorter than monostable");
        if (2 * NUM_PRIME > PSSW_DW)
            $error("selection fields exceed a data word");
    end

    // ************************************************************
    // registers
    // ************************************************************
    logic [3:0]             ctrl_reg;
    logic [2*NUM_PRIME-1:0] modsel_reg;
    logic [2*NUM_PRIME-1:0] demsel_reg;
    logic [3:0]             fault_reg;
    logic [NUM_PRIME-1:0]   rxflt_reg;
    logic [NUM_PRIME-1:0]   txflt_reg;

    wire remote = ctrl_reg[PSSW_CTRL_REMOTE];

    // ************************************************************
    // control register
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg <= PSSW_CTRL_RST;
        end else if (wr && addr == PSSW_REG_CTRL) begin
            ctrl_reg <= wdata[3:0];
        end
    end

    // ************************************************************
    // selection registers
    // ************************************************************
    // selections accepted only in remote mode; reset returns to prime
    // a selection written in automatic mode is dropped, not queued
    always_ff @(posedge clk) begin
        if (reset) begin
            modsel_reg <= '0;
        end else if (wr && addr == PSSW_REG_MODSEL && remote) begin
            modsel_reg <= wdata[2*NUM_PRIME-1:0];
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            demsel_reg <= '0;
        end else if (wr && addr == PSSW_REG_DEMSEL && remote) begin
            demsel_reg <= wdata[2*NUM_PRIME-1:0];
        end
    end

    // ************************************************************
    // fault causes
    // ************************************************************
    // software sets, hardware keeps until the cause is cleared
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_reg <= '0;
        end else if (wr && addr == PSSW_REG_FAULT) begin
            fault_reg <= wdata[3:0];
        end
    end

    // ************************************************************
    // fault inputs, prime modem ports only; backup lines are used unregistered
    // ************************************************************
    // one stage only: the lines arrive synchronous to clk
    always_ff @(posedge clk) begin
        if (reset) begin
            txflt_reg <= '0;
        end else begin
            txflt_reg <= tx_unit_fault_in;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rxflt_reg <= '0;
        end else begin
            rxflt_reg <= rx_unit_fault_in;
        end
    end

    // ************************************************************
    // effective selection per prime
    // ************************************************************
    logic [2*NUM_PRIME-1:0] tx_sel;
    logic [2*NUM_PRIME-1:0] rx_sel;

    always_comb begin
        tx_sel = modsel_reg;
        rx_sel = demsel_reg;
        for (int i = 0; i < NUM_PRIME; i++) begin
            if (ctrl_reg[PSSW_CTRL_WHOLE]) begin
                // whole-modem: either side fault moves both groups
                if (txflt_reg[i] || rxflt_reg[i]) begin
                    if (modsel_reg[2*i +: 2] != PSSW_SEL_PRIME)
                        rx_sel[2*i +: 2] = modsel_reg[2*i +: 2];
                    else
                        tx_sel[2*i +: 2] = demsel_reg[2*i +: 2];
                end else begin
                    rx_sel[2*i +: 2] = modsel_reg[2*i +: 2];
                end
            end
            // a faulty backup cannot take traffic; fall back to prime
            if (tx_sel[2*i] && bu_tx_fault_in[tx_sel[2*i+1]])
                tx_sel[2*i +: 2] = PSSW_SEL_PRIME;
            if (rx_sel[2*i] && bu_rx_fault_in[rx_sel[2*i+1]])
                rx_sel[2*i +: 2] = PSSW_SEL_PRIME;
            // code 10 names no backup; fold it to prime so routes
            // and online outputs never disagree
            if (!tx_sel[2*i])
                tx_sel[2*i+1] = 1'b0;
            if (!rx_sel[2*i])
                rx_sel[2*i+1] = 1'b0;
        end
    end

    // ************************************************************
    // routing and clock steering
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_route <= '0;
            rx_route <= '0;
        end else begin
            tx_route <= tx_sel;
            rx_route <= rx_sel;
        end
    end

    // clocks go to whichever unit stands by, never to a busy backup
    always_ff @(posedge clk) begin
        if (reset) begin
            clk_to_prime  <= '0;
            clk_to_backup <= '0;
        end else begin
            for (int i = 0; i < NUM_PRIME; i++) begin
                // offline prime gets clocks so it stands by hot
                clk_to_prime[i] <= tx_sel[2*i] | rx_sel[2*i];
            end
            for (int b = 0; b < PSSW_NUM_BACKUP; b++) begin
                clk_to_backup[b] <= 1'b1;
                for (int i = 0; i < NUM_PRIME; i++) begin
                    if ((tx_sel[2*i] && tx_sel[2*i+1] == b[0]) ||
                        (rx_sel[2*i] && rx_sel[2*i+1] == b[0]))
                        clk_to_backup[b] <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // pole groups
    // ************************************************************
    // pole count per group follows the routing unit type
    always_ff @(posedge clk) begin
        if (reset) begin
            pole_mask <= '0;
        end else if (ctrl_reg[PSSW_CTRL_RS449]) begin
            pole_mask <= {PSSW_POLES_RS449{1'b1}};
        end else begin
            pole_mask <= {{(PSSW_POLES_RS449-PSSW_POLES_V35){1'b0}},
                          {PSSW_POLES_V35{1'b1}}};
        end
    end

    // ************************************************************
    // online telemetry
    // ************************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            mod_online <= '0;
        end else begin
            for (int i = 0; i < NUM_PRIME; i++) begin
                mod_online[i] <= tx_sel[2*i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            demod_online <= '0;
        end else begin
            for (int i = 0; i < NUM_PRIME; i++) begin
                demod_online[i] <= rx_sel[2*i];
            end
        end
    end

    // ************************************************************
    // controller watchdog monostable
    // ************************************************************
    // the kick only runs while the controller is marked running, so a
    // stopped controller lets the monostable expire on its own
    // limitation: loss of power is seen only as the relay dropping
    logic [$clog2(KICK_CYC+1)-1:0] kick_cnt_reg;
    logic [$clog2(MONO_CYC+1)-1:0] mono_cnt_reg;
    logic                          kick;

    always_ff @(posedge clk) begin
        if (reset || !ctrl_reg[PSSW_CTRL_RUN]) begin
            kick_cnt_reg <= '0;
            kick         <= 1'b0;
        end else if (kick_cnt_reg == KICK_CYC[$bits(kick_cnt_reg)-1:0] - 1'b1)
        begin
            kick_cnt_reg <= '0;
            kick         <= 1'b1;
        end else begin
            kick_cnt_reg <= kick_cnt_reg + 1'b1;
            kick         <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mono_cnt_reg <= '0;
        end else if (kick) begin
            mono_cnt_reg <= MONO_CYC[$bits(mono_cnt_reg)-1:0];
        end else if (mono_cnt_reg != '0) begin
            mono_cnt_reg <= mono_cnt_reg - 1'b1;
        end
    end

    // ************************************************************
    // summary alarms
    // ************************************************************
    logic all_lost;

    // first pass: any unit lost; second pass: any carrier clears it
    always_comb begin
        all_lost = 1'b0;
        for (int i = 0; i < NUM_PRIME; i++) begin
            // an active demodulator is the unit carrying receive traffic
            if (rx_sel[2*i] ? bu_rx_fault_in[rx_sel[2*i+1]] : rxflt_reg[i])
                all_lost = 1'b1;
        end
        for (int i = 0; i < NUM_PRIME; i++) begin
            if (!(rx_sel[2*i] ? bu_rx_fault_in[rx_sel[2*i+1]]
                              : rxflt_reg[i]))
                all_lost = 1'b0;
        end
    end

    // ************************************************************
    // alarm relays
    // ************************************************************
    // one register stage so no relay coil ever sees a glitch
    always_ff @(posedge clk) begin
        if (reset) begin
            alarm <= '0;
        end else begin
            alarm.ctrl_ok    <= (mono_cnt_reg != '0);
            alarm.prot_fault <= |fault_reg;
            alarm.rx_fault   <= all_lost;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    // reads have no side effects, so polling never clears a cause
    always_ff @(posedge clk) begin
        if (reset) begin
            rdata <= '0;
        end else if (rd) begin
            if (addr == PSSW_REG_CTRL)
                rdata <= {28'h0000000, ctrl_reg};
            else if (addr == PSSW_REG_MODSEL)
                rdata <= PSSW_DW'(modsel_reg);
            else if (addr == PSSW_REG_DEMSEL)
                rdata <= PSSW_DW'(demsel_reg);
            else if (addr == PSSW_REG_FAULT)
                rdata <= {28'h0000000, fault_reg};
            else if (addr == PSSW_REG_STATUS)
                rdata <= {29'h0, alarm};
            else if (addr == PSSW_REG_ONLINE)
                rdata <= PSSW_DW'({demod_online, mod_online});
            else if (addr == PSSW_REG_RXFLT)
                rdata <= PSSW_DW'(rxflt_reg);
            else if (addr == PSSW_REG_TXFLT)
                rdata <= PSSW_DW'(txflt_reg);
            else
                rdata <= '0;
        end else begin
            rdata <= '0;
        end
    end

endmodule : pssw_status

/* File: sim/pssw_status_monitor.sv */
// Purpose: port-level checks of the status block
// Assumes: synchronous active-high reset, two-flop output path
// Notes:   monostable figures come from the bound parameters
`timescale 1ns/1ps
module pssw_status_monitor
    import pssw_pkg::*;
#(
    parameter int NUM_PRIME = PSSW_NUM_PRIME,
    parameter int MONO_CYC  = PSSW_MONO_CYC,
    parameter int KICK_CYC  = PSSW_KICK_CYC
) (
    // clock, reset and register port
    input wire logic                   clk,
    input wire logic                   reset,
    input wire logic [PSSW_AW-1:0]     addr,
    input wire logic [PSSW_DW-1:0]     wdata,
    input wire logic                   wr,
    // modem and relay side
    input wire logic [NUM_PRIME-1:0]   rx_unit_fault_in,
    input wire pssw_alarm_t            alarm,
    input wire logic [NUM_PRIME-1:0]   mod_online,
    input wire logic [NUM_PRIME-1:0]   demod_online,
    input wire logic [2*NUM_PRIME-1:0] tx_route,
    input wire logic [2*NUM_PRIME-1:0] rx_route,
    input wire logic [9:0]             pole_mask,
    input wire logic [NUM_PRIME-1:0]   clk_to_prime,
    input wire logic [1:0]             clk_to_backup
);
    logic                 run_reg;
    logic [NUM_PRIME-1:0] tx_bu, rx_bu;
    int                   on_cnt, off_cnt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // shadow of the run bit, since the block keeps its copy inside
    always_ff @(posedge clk) begin
        if (reset) begin
            run_reg <= 1'b0;
        end else if (wr && addr == PSSW_REG_CTRL) begin
            run_reg <= wdata[PSSW_CTRL_RUN];
        end
    end
    // saturating, so a long run cannot wrap the count
    always_ff @(posedge clk) begin
        if (reset || !run_reg) begin
            on_cnt <= 0;
        end else if (on_cnt < 5000) begin
            on_cnt <= on_cnt + 1;
        end
    end
    always_ff @(posedge clk) begin
        if (reset || run_reg) begin
            off_cnt <= 0;
        end else if (off_cnt < 5000) begin
            off_cnt <= off_cnt + 1;
        end
    end
    always_comb begin
        for (int i = 0; i < NUM_PRIME; i++) begin
            tx_bu[i] = tx_route[2*i +: 2] != 2'b00;
            rx_bu[i] = rx_route[2*i +: 2] != 2'b00;
        end
    end

    a_reset_prime: assert property (
        $fell(reset) |-> alarm == '0 && {tx_route, rx_route} == '0)
        else $error("routes or alarms not clear after reset");
    a_wdog_alive: assert property (
        on_cnt > KICK_CYC + 4 |-> alarm.ctrl_ok)
        else $error("controller relay dropped while kicked");
    a_wdog_drop: assert property (
        off_cnt > MONO_CYC + 4 |-> !alarm.ctrl_ok)
        else $error("controller relay held without kicks");
    a_prot_raise: assert property (
        wr && addr == PSSW_REG_FAULT && wdata[3:0] != 4'h0
        |-> ##2 alarm.prot_fault)
        else $error("protection fault not raised");
    a_prot_hold: assert property (
        $fell(alarm.prot_fault) |-> $past(wr && addr == PSSW_REG_FAULT, 2))
        else $error("protection fault cleared without a write");
    a_rx_all_lost: assert property (
        (&rx_unit_fault_in && demod_online == '0) [*3] |-> alarm.rx_fault)
        else $error("receive fault missing with all carriers lost");
    a_rx_clear: assert property (
        (!rx_unit_fault_in[0] && !demod_online[0]) [*3] |-> !alarm.rx_fault)
        else $error("receive fault with a carrier present");
    a_mod_online: assert property (
        mod_online == tx_bu)
        else $error("modulator online disagrees with route");
    a_dem_online: assert property (
        demod_online == rx_bu)
        else $error("demodulator online disagrees with route");
    a_pole_set: assert property (
        wr && addr == PSSW_REG_CTRL |-> ##2 pole_mask ==
        ($past(wdata[PSSW_CTRL_RS449], 2) ? 10'h3FF : 10'h0FF))
        else $error("pole group size wrong");
    a_clk_idle: assert property (
        ({tx_route, rx_route} == '0) [*3]
        |-> clk_to_backup == 2'b11 && clk_to_prime == '0)
        else $error("clocks not on idle backups");
endmodule : pssw_status_monitor

bind pssw_status pssw_status_monitor #(
    .NUM_PRIME(NUM_PRIME), .MONO_CYC(MONO_CYC), .KICK_CYC(KICK_CYC)
) i_mon (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rx_unit_fault_in(rx_unit_fault_in), .alarm(alarm),
    .mod_online(mod_online), .demod_online(demod_online),
    .tx_route(tx_route), .rx_route(rx_route), .pole_mask(pole_mask),
    .clk_to_prime(clk_to_prime), .clk_to_backup(clk_to_backup));

/* File: sim/pssw_modem_model.sv */
// Purpose: prime and backup modems driving their fault lines
// Assumes: bench changes wanted faults just after a clock edge
// Notes:   slow adds a cycle of lag, like a sluggish modem
`timescale 1ns/1ps
module pssw_modem_model (
    // clock and lag select
    input  wire logic        clk,
    input  wire logic        slow,
    // wanted faults {bu tx, tx, bu rx, rx}
    input  wire logic [19:0] want,
    // fault lines toward the switch
    output logic      [19:0] fault
);
    logic [19:0] want_d1, want_d2;

    always_ff @(posedge clk) begin
        want_d1 <= want;
        want_d2 <= want_d1;
    end
    // a modem always drives a level, so no released state exists
    assign fault = slow ? want_d2 : want_d1;
endmodule : pssw_modem_model

/* File: sim/pssw_status_tb.sv */
// Purpose: self-checking bench of the status block
// Assumes: short monostable and kick counts
// Notes:   read data are judged from a queue of expected words
`timescale 1ns/1ps
module pssw_status_tb;
    import pssw_pkg::*;
    localparam int MONO = 40;
    localparam int KICK = 10;

    logic        clk, reset, wr, rd, rd_d, slow;
    logic [3:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [19:0] want, flt;
    logic [15:0] txr, rxr;
    logic [7:0]  mod_on, dem_on, c2p;
    logic [9:0]  poles;
    logic [1:0]  c2b;
    pssw_alarm_t alarm;
    logic [31:0] exp_q[$];
    int          err_total, checks_done, cyc, seed, p, q;

    pssw_status #(.MONO_CYC(MONO), .KICK_CYC(KICK)) i_dut (
        .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .tx_unit_fault_in(flt[17:10]),
        .rx_unit_fault_in(flt[7:0]), .bu_tx_fault_in(flt[19:18]),
        .bu_rx_fault_in(flt[9:8]), .alarm(alarm), .mod_online(mod_on),
        .demod_online(dem_on), .tx_route(txr), .rx_route(rxr),
        .pole_mask(poles), .clk_to_prime(c2p), .clk_to_backup(c2b));
    pssw_modem_model i_modems (.clk(clk), .slow(slow), .want(want),
        .fault(flt));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic results;
        if (err_total == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: %h expected %h", $time, got, exp);
        end
    endtask : cmp
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick
    // the second edge keeps a strobe from being set and cleared at once
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= w;
        rd    <= !w;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask : bus
    task automatic rreg(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 32'h0);
    endtask : rreg

    // read data stand only in the cycle after the strobe
    always @(posedge clk) begin
        rd_d <= rd;
        if (rd_d && exp_q.size() > 0) begin
            cmp(rdata, exp_q.pop_front());
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            results();
        end
    end

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        seed = 32'h3d51;
        {reset, wr, rd, slow} = 4'b1000;
        addr = 4'h0;
        wdata = 32'h0;
        want = 20'h0;
        tick(4);
        reset <= 1'b0;
        tick(2);
        cmp({txr, rxr}, 32'h0);
        cmp({dem_on, mod_on, c2p, 5'h0, alarm}, 32'h0);
        cmp(32'({c2b, poles}), 32'h00000CFF);
        rreg(PSSW_REG_CTRL, 32'h0);
        bus(1'b1, 4'hF, 32'hFFFFFFFF);
        rreg(4'hF, 32'h0);
        bus(1'b1, PSSW_REG_MODSEL, 32'h4);
        tick(3);
        cmp(32'(txr), 32'h0);
        bus(1'b1, PSSW_REG_CTRL, 32'h5);
        tick(KICK + 6);
        rreg(PSSW_REG_STATUS, 32'h4);
        for (int i = 0; i < 16; i++) begin
            p = i % 8;
            q = 7 - p;
            v = (i < 8) ? 32'h1 : 32'h3;
            bus(1'b1, PSSW_REG_MODSEL, v << (2 * p));
            bus(1'b1, PSSW_REG_DEMSEL, (v ^ 32'h2) << (2 * q));
            tick(3);
            cmp({txr, rxr}, {16'(v << 2*p), 16'((v ^ 32'h2) << 2*q)});
            cmp(32'({mod_on, dem_on}), 32'({8'(1 << p), 8'(1 << q)}));
            cmp(32'(c2p), 32'((1 << p) | (1 << q)));
            cmp(32'(c2b), 32'h0);
        end
        rreg(PSSW_REG_ONLINE, 32'h0180);
        bus(1'b1, PSSW_REG_MODSEL, 32'h0);
        bus(1'b1, PSSW_REG_CTRL, 32'h7);
        bus(1'b1, PSSW_REG_DEMSEL, 32'h1);
        tick(2);
        cmp({txr, rxr}, 32'h0);
        slow <= 1'b1;
        want <= 20'h00001;
        tick(7);
        cmp({txr, rxr}, 32'h00010001);
        want <= 20'h0;
        slow <= 1'b0;
        bus(1'b1, PSSW_REG_DEMSEL, 32'h0);
        bus(1'b1, PSSW_REG_CTRL, 32'h5);
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, PSSW_REG_FAULT, 32'h1 << i);
            tick(2);
            cmp(32'(alarm.prot_fault), 32'h1);
            rreg(PSSW_REG_FAULT, 32'h1 << i);
            bus(1'b1, PSSW_REG_FAULT, 32'h0);
            tick(2);
            cmp(32'(alarm.prot_fault), 32'h0);
        end
        for (int k = 0; k < 8; k++) begin
            v = $random(seed);
            if (k % 3 == 0) v[7:0] = 8'hFF;
            want <= v[19:0];
            tick(5);
            cmp(32'(alarm.rx_fault), 32'(&v[7:0]));
            rreg(PSSW_REG_RXFLT, 32'(v[7:0]));
            rreg(PSSW_REG_TXFLT, 32'(v[17:10]));
        end
        want <= 20'h0;
        bus(1'b1, PSSW_REG_CTRL, 32'hD);
        tick(2);
        cmp(32'(poles), 32'h3FF);
        bus(1'b1, PSSW_REG_CTRL, 32'h0);
        tick(MONO + 6);
        cmp({29'h0, alarm}, 32'h0);
        cmp(32'(poles), 32'h0FF);
        bus(1'b1, PSSW_REG_CTRL, 32'h5);
        bus(1'b1, PSSW_REG_MODSEL, 32'h4);
        tick(2);
        reset <= 1'b1;
        tick(2);
        reset <= 1'b0;
        tick(2);
        cmp({txr, 8'h0, mod_on}, 32'h0);
        rreg(PSSW_REG_MODSEL, 32'h0);
        tick(2);
        results();
    end
endmodule : pssw_status_tb
